/* File: inc/tpsic_regs.svh */
// Register indices, field positions and reset values of the power,
// status and alert block. Included by the design files and the bench.
`ifndef TPSIC_REGS_SVH
`define TPSIC_REGS_SVH

// Register indices; the AXI4-Lite byte address is four times the index.
`define TPSIC_IDX_CTRL       6'h00
`define TPSIC_IDX_GENERAL    6'h02
`define TPSIC_IDX_TOUCH      6'h03
`define TPSIC_IDX_LIGHT      6'h04
`define TPSIC_IDX_LOW_POWER_SCAN_EN_SEL   6'h08
`define TPSIC_IDX_TOUCH_IRQ  6'h09
`define TPSIC_IDX_PAT_IRQ    6'h0A
`define TPSIC_IDX_LINK       6'h0B

// Byte address bits that select the register index.
`define TPSIC_ADDR_IDX_HI    7
`define TPSIC_ADDR_IDX_LO    2

// Main power control fields.
`define TPSIC_CTRL_GAIN_HI   7
`define TPSIC_CTRL_GAIN_LO   6
`define TPSIC_CTRL_LOW_POWER_SCAN_EN      5
`define TPSIC_CTRL_DEEP      4
`define TPSIC_CTRL_INT       0

// General event summary fields.
`define TPSIC_GEN_LIGHT      4
`define TPSIC_GEN_RESET      3
`define TPSIC_GEN_MULTI_TOUCH_BLOCK_FLAG       2
`define TPSIC_GEN_PAT        1
`define TPSIC_GEN_TOUCH      0

// Pattern alert enable field.
`define TPSIC_PAT_IRQ_EN     0

// Gain codes and the sensing gain factor each selects.
`define TPSIC_GAIN_X1        2'h0
`define TPSIC_GAIN_X2        2'h1
`define TPSIC_GAIN_X4        2'h2
`define TPSIC_GAIN_X8        2'h3
`define TPSIC_FACTOR_X1      4'h1
`define TPSIC_FACTOR_X2      4'h2
`define TPSIC_FACTOR_X4      4'h4
`define TPSIC_FACTOR_X8      4'h8

// Reset values.
`define TPSIC_RST_BYTE       8'h00
`define TPSIC_RST_LOW_POWER_SCAN_EN_SEL   8'h01
`define TPSIC_RST_TOUCH_IRQ  8'hFF
`define TPSIC_ALL_CHANNELS   8'hFF
`define TPSIC_RSP_OKAY       2'h0
`define TPSIC_DATA_ZERO      32'h0000_0000

`endif

/* File: inc/tpsic_pkg.sv */
// Types shared by the power, status and alert block and its bus slave.
// Assumes the register header is on the include path.
package tpsic_pkg;

   typedef struct packed {
      logic [1:0] gain;
      logic       standby;
      logic       deep;
      logic       intPend;
   } tpsic_ctrl_t;

   // Event and level inputs from the sensing and light engines.
   typedef struct packed {
      logic [7:0] touch;
      logic       multiBlock;
      logic       patternHit;
      logic [7:0] lightDone;
      logic       resetExit;
   } tpsic_evt_t;

   // Controls handed back to the sensing and light engines.
   typedef struct packed {
      logic [7:0] scanEn;
      logic [7:0] touchState;
      logic [3:0] gainFactor;
      logic       lightsInactive;
      logic       pwmEn;
      logic [7:0] linkMask;
   } tpsic_sense_t;

   typedef struct packed {
      tpsic_ctrl_t ctrl;
      logic [7:0]  touchFlags;
      logic [7:0]  lightDone;
      logic        resetFlag;
      logic        patternFlag;
      logic [7:0]  stbySel;
      logic [7:0]  touchIrqEn;
      logic        patternIrqEn;
      logic [7:0]  linkMask;
      logic [7:0]  touchPrev;
      logic        patternPrev;
      logic        porPend;
      logic        wakeFlag;
   } tpsic_state_t;

   typedef struct packed {
      logic       awFull;
      logic [5:0] awIdx;
      logic       wFull;
      logic [7:0] wData;
      logic       wLane;
      logic       bValid;
      logic       rValid;
      logic [7:0] rData;
   } tpsic_bus_state_t;

endpackage

/* File: logic/tpsic_axil_slave.sv */
// AXI4-Lite slave that turns bus accesses into one-cycle register writes
// and registered reads of eight-bit registers in the low byte lane.
// Assumes a master that keeps at most one write and one read under way.
`timescale 1ns/1ns
`include "tpsic_regs.svh"
module tpsic_axil_slave (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wrEn,
   output logic [5:0]       wrIdx,
   output logic [7:0]       wrData,
   output logic [5:0]       rdIdx,
   input  wire logic [7:0]  rdData
);
   tpsic_pkg::tpsic_bus_state_t s_reg;
   tpsic_pkg::tpsic_bus_state_t s_next;

   assign s_axi_awready = !s_reg.awFull && !s_reg.bValid;
   assign s_axi_wready  = !s_reg.wFull && !s_reg.bValid;
   assign s_axi_arready = !s_reg.rValid;
   assign s_axi_bvalid  = s_reg.bValid;
   assign s_axi_rvalid  = s_reg.rValid;
   assign s_axi_bresp   = `TPSIC_RSP_OKAY;
   assign s_axi_rresp   = `TPSIC_RSP_OKAY;
   assign s_axi_rdata   = {24'h00_0000, s_reg.rData};
   // A write without the low lane enabled is answered but stores nothing.
   assign wrEn   = s_reg.awFull && s_reg.wFull && !s_reg.bValid
                   && s_reg.wLane;
   assign wrIdx  = s_reg.awIdx;
   assign wrData = s_reg.wData;
   assign rdIdx  = s_axi_araddr[`TPSIC_ADDR_IDX_HI:`TPSIC_ADDR_IDX_LO];

   always_comb begin
      s_next = s_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.awFull = 1'b1;
         s_next.awIdx  = s_axi_awaddr[`TPSIC_ADDR_IDX_HI:`TPSIC_ADDR_IDX_LO];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.wFull = 1'b1;
         s_next.wData = s_axi_wdata[7:0];
         s_next.wLane = s_axi_wstrb[0];
      end
      if (s_reg.awFull && s_reg.wFull && !s_reg.bValid) begin
         s_next.awFull = 1'b0;
         s_next.wFull  = 1'b0;
         s_next.bValid = 1'b1;
      end
      if (s_reg.bValid && s_axi_bready) begin
         s_next.bValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rValid = 1'b1;
         s_next.rData  = rdData;
      end else if (s_reg.rValid && s_axi_rready) begin
         s_next.rValid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: logic/tpsic_top.sv */
// Power state control, event status and alert logic of an eight-input
// touch controller with eight light drivers, behind an AXI4-Lite slave.
// Assumes sensing and light engines outside that report touch levels,
// done pulses, pattern and blocking levels, and obey the controls here.
//
// Behaviour
// - Gain field bits 7:6 selects sensing gain 1, 2, 4 or 8.
// - Selected gain applies equally in active and standby states.
// - Standby bit 5 limits scanning to the standby channel selection.
// - In standby, status contents are held, not cleared automatically.
// - Inputs no longer sampled report one release, then stay untouched.
// - In standby, tied lights stay tied; host-driven lights are unchanged.
// - Deep-sleep bit 4 stops scanning, forces lights inactive, stops PWM.
// - Entering deep sleep clears all status bits except blocking bit 2, and the pending bit.
// - Wake input high clears the deep-sleep bit.
// - Active-low alert is asserted while pending bit 0 is one.
// - Touch on a channel with interrupt disabled never sets pending.
// - Host writes zero to pending; alert drops, gone conditions clear.
// - Wake output raised by a standby touch drops when pending clears.
// - In four-wire SPI mode the wake pin is never driven.
// - Light summary bit 4 is the OR of the light done flags.
// - Reset flag bit 3 sets after reset, sets pending, clears with it.
// - Multi-touch blocking bit 2 shows suppression, never sets pending.
// - Pattern bit 1 sets pending if enabled; holds until condition goes.
// - Touch summary bit 0 is the OR of the touch flags.
// - Touch flags hold one bit per input, input 1 at bit 0.
// - Persisting touch keeps its flag on clear but does not re-alert.
// - Done flags set on host-driven lights, ignore tied, clear with pending.
`timescale 1ns/1ns
`include "tpsic_regs.svh"
module tpsic_top (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic [31:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [31:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire tpsic_pkg::tpsic_evt_t evt,
   output tpsic_pkg::tpsic_sense_t    sense,
   input  wire logic                  spi4Wire,
   input  wire logic                  wakeIn,
   output logic                       wakeOut,
   output logic                       wakeOe,
   output logic                       alert_n
);
   tpsic_pkg::tpsic_state_t s_reg;
   tpsic_pkg::tpsic_state_t s_next;

   logic       wrEn;
   logic [5:0] wrIdx;
   logic [7:0] wrData;
   logic [5:0] rdIdx;
   logic [7:0] rdData;
   logic [7:0] scanEn;
   logic [7:0] effTouch;
   logic [7:0] newTouch;
   logic [7:0] alertTouch;
   logic [7:0] generalSummary;
   logic [7:0] ctrlByte;
   logic       intClear;
   logic       patternRise;
   logic       raiseInt;
   logic [3:0] gainFactor;

   tpsic_axil_slave u_bus (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wrEn          (wrEn),
      .wrIdx         (wrIdx),
      .wrData        (wrData),
      .rdIdx         (rdIdx),
      .rdData        (rdData)
   );

   always_comb begin
      if (s_reg.ctrl.deep) begin
         scanEn = 8'h00;
      end else if (s_reg.ctrl.standby) begin
         scanEn = s_reg.stbySel;
      end else begin
         scanEn = `TPSIC_ALL_CHANNELS;
      end
   end

   // unsampled inputs release
   // Masking the touch level makes the sampled state fall exactly once.
   assign effTouch    = evt.touch & scanEn;
   assign newTouch    = effTouch & ~s_reg.touchPrev;
   assign alertTouch  = newTouch & s_reg.touchIrqEn;
   assign patternRise = evt.patternHit && !s_reg.patternPrev;
   assign intClear    = wrEn && (wrIdx == `TPSIC_IDX_CTRL)
                        && !wrData[`TPSIC_CTRL_INT];

   assign raiseInt = (|alertTouch)
                     || (patternRise && s_reg.patternIrqEn)
                     || s_reg.porPend || evt.resetExit;

   always_comb begin
      s_next = s_reg;
      s_next.touchPrev   = effTouch;
      s_next.patternPrev = evt.patternHit;
      s_next.porPend     = 1'b0;

      if (wrEn) begin
         case (wrIdx)
            `TPSIC_IDX_CTRL: begin
               s_next.ctrl.gain =
                  wrData[`TPSIC_CTRL_GAIN_HI:`TPSIC_CTRL_GAIN_LO];
               s_next.ctrl.standby = wrData[`TPSIC_CTRL_LOW_POWER_SCAN_EN];
               s_next.ctrl.deep    = wrData[`TPSIC_CTRL_DEEP];
               s_next.ctrl.intPend = wrData[`TPSIC_CTRL_INT];
            end
            `TPSIC_IDX_LOW_POWER_SCAN_EN_SEL: begin
               s_next.stbySel = wrData;
            end
            `TPSIC_IDX_TOUCH_IRQ: begin
               s_next.touchIrqEn = wrData;
            end
            `TPSIC_IDX_PAT_IRQ: begin
               s_next.patternIrqEn = wrData[`TPSIC_PAT_IRQ_EN];
            end
            `TPSIC_IDX_LINK: begin
               s_next.linkMask = wrData;
            end
            default: begin
               s_next.linkMask = s_reg.linkMask;
            end
         endcase
      end

      if (intClear) begin
         s_next.touchFlags = s_reg.touchFlags & effTouch;
         s_next.lightDone  = 8'h00;
         s_next.resetFlag  = 1'b0;
         s_next.wakeFlag   = 1'b0;
      end

      if (!evt.patternHit) begin
         s_next.patternFlag = 1'b0;
      end

      // Events land after the clears so that a set in the clearing cycle
      // is never lost. Only deep-sleep entry also clears these flags, in standby too.
      // status held
      s_next.touchFlags = s_next.touchFlags | newTouch;
      s_next.lightDone = s_next.lightDone
                         | (evt.lightDone & ~s_reg.linkMask);
      if (s_reg.porPend || evt.resetExit) begin
         s_next.resetFlag = 1'b1;
      end
      if (evt.patternHit) begin
         s_next.patternFlag = 1'b1;
      end
      if (raiseInt) begin
         s_next.ctrl.intPend = 1'b1;
      end
      if (s_reg.ctrl.standby && (|alertTouch)) begin
         s_next.wakeFlag = 1'b1;
      end

      if (wakeIn) begin
         s_next.ctrl.deep = 1'b0;
      end

      if (s_next.ctrl.deep && !s_reg.ctrl.deep) begin
         s_next.touchFlags   = 8'h00;
         s_next.lightDone    = 8'h00;
         s_next.resetFlag    = 1'b0;
         s_next.patternFlag  = 1'b0;
         s_next.ctrl.intPend = 1'b0;
         s_next.wakeFlag     = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg              <= '0;
         s_reg.stbySel      <= `TPSIC_RST_LOW_POWER_SCAN_EN_SEL;
         s_reg.touchIrqEn   <= `TPSIC_RST_TOUCH_IRQ;
         // The reset exit event is raised by the first edge after release.
         s_reg.porPend      <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      generalSummary = `TPSIC_RST_BYTE;
      generalSummary[`TPSIC_GEN_TOUCH] = |s_reg.touchFlags;
      generalSummary[`TPSIC_GEN_PAT]   = s_reg.patternFlag;
      generalSummary[`TPSIC_GEN_MULTI_TOUCH_BLOCK_FLAG]  = evt.multiBlock;
      generalSummary[`TPSIC_GEN_RESET] = s_reg.resetFlag;
      generalSummary[`TPSIC_GEN_LIGHT] = |s_reg.lightDone;
   end

   always_comb begin
      ctrlByte = `TPSIC_RST_BYTE;
      ctrlByte[`TPSIC_CTRL_GAIN_HI:`TPSIC_CTRL_GAIN_LO] = s_reg.ctrl.gain;
      ctrlByte[`TPSIC_CTRL_LOW_POWER_SCAN_EN] = s_reg.ctrl.standby;
      ctrlByte[`TPSIC_CTRL_DEEP] = s_reg.ctrl.deep;
      ctrlByte[`TPSIC_CTRL_INT]  = s_reg.ctrl.intPend;
   end

   // Unmapped indices read as zero and writes to them have no effect.
   always_comb begin
      case (rdIdx)
         `TPSIC_IDX_CTRL: begin
            rdData = ctrlByte;
         end
         `TPSIC_IDX_GENERAL: begin
            rdData = generalSummary;
         end
         `TPSIC_IDX_TOUCH: begin
            rdData = s_reg.touchFlags;
         end
         `TPSIC_IDX_LIGHT: begin
            rdData = s_reg.lightDone;
         end
         `TPSIC_IDX_LOW_POWER_SCAN_EN_SEL: begin
            rdData = s_reg.stbySel;
         end
         `TPSIC_IDX_TOUCH_IRQ: begin
            rdData = s_reg.touchIrqEn;
         end
         `TPSIC_IDX_PAT_IRQ: begin
            rdData = {7'h00, s_reg.patternIrqEn};
         end
         `TPSIC_IDX_LINK: begin
            rdData = s_reg.linkMask;
         end
         default: begin
            rdData = `TPSIC_RST_BYTE;
         end
      endcase
   end

   always_comb begin
      case (s_reg.ctrl.gain)
         `TPSIC_GAIN_X1: begin
            gainFactor = `TPSIC_FACTOR_X1;
         end
         `TPSIC_GAIN_X2: begin
            gainFactor = `TPSIC_FACTOR_X2;
         end
         `TPSIC_GAIN_X4: begin
            gainFactor = `TPSIC_FACTOR_X4;
         end
         `TPSIC_GAIN_X8: begin
            gainFactor = `TPSIC_FACTOR_X8;
         end
         default: begin
            gainFactor = `TPSIC_FACTOR_X1;
         end
      endcase
   end

   assign sense.gainFactor = gainFactor;
   assign sense.scanEn     = scanEn;
   assign sense.touchState = s_reg.touchPrev;
   assign sense.lightsInactive = s_reg.ctrl.deep;
   assign sense.pwmEn          = !s_reg.ctrl.deep;
   assign sense.linkMask = s_reg.linkMask;

   assign alert_n = !s_reg.ctrl.intPend;
   // no wake drive on SPI4
   // The pin is driven only while asserted, so the host can still drive
   // it high to end deep sleep.
   assign wakeOe  = s_reg.wakeFlag && !spi4Wire;
   assign wakeOut = s_reg.wakeFlag;
endmodule

/* File: test/tpsic_assertions.sv */
// Concurrent checks on the pins of the power, status and alert block.
// Assumes one clock domain and is bound to the top by the bench.
`timescale 1ns/1ns
module tpsic_assertions (
   input wire logic                    clk,
   input wire logic                    sys_rst,
   input wire tpsic_pkg::tpsic_evt_t   evt,
   input wire tpsic_pkg::tpsic_sense_t sense,
   input wire logic                    spi4Wire,
   input wire logic                    wakeIn,
   input wire logic                    wakeOut,
   input wire logic                    wakeOe,
   input wire logic                    alert_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_por_raises_alert: assert property ($fell(sys_rst) |=> !alert_n)
      else $error("alert not raised after reset release");
   a_exit_pulse_alert: assert property (evt.resetExit |=> !alert_n)
      else $error("alert not raised by reset exit pulse");
   a_no_wake_spi4: assert property (spi4Wire |-> !wakeOe)
      else $error("wake pin driven in four-wire mode");
   a_wake_drops_clear: assert property ($rose(alert_n) |-> !wakeOut)
      else $error("wake output still high after pending cleared");
   a_deep_stops_all: assert property (
      sense.lightsInactive |-> sense.scanEn == 8'h00 && !sense.pwmEn)
      else $error("scanning or modulation active in deep sleep");
   a_wake_ends_deep: assert property (wakeIn |=> !sense.lightsInactive)
      else $error("deep sleep kept after wake input");
   a_gain_one_hot: assert property ($onehot(sense.gainFactor))
      else $error("gain factor not one of 1, 2, 4, 8");
   a_block_no_alert: assert property (
      alert_n && evt.multiBlock && !evt.patternHit && !evt.resetExit &&
      evt.touch == 8'h00 && evt.lightDone == 8'h00 |=> alert_n)
      else $error("blocking flag raised the alert");
   a_release_follows: assert property (
      !$past(sys_rst) |->
      sense.touchState == ($past(evt.touch) & $past(sense.scanEn)))
      else $error("touch state does not follow scanned inputs");
endmodule

/* File: test/tpsic_host_model.sv */
// Host model: an AXI4-Lite master with one write and one read task.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ns
module tpsic_host_model (
   input  wire logic  clk,
   output logic [31:0] awaddr,
   output logic        awvalid,
   input  wire logic  awready,
   output logic [31:0] wdata,
   output logic        wvalid,
   input  wire logic  wready,
   input  wire logic  bvalid,
   output logic        bready,
   output logic [31:0] araddr,
   output logic        arvalid,
   input  wire logic  arready,
   input  wire logic  rvalid,
   output logic        rready
);
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = '0;
   end

   // Each channel holds its payload until its own ready is seen.
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr <= {24'h00_0000, idx, 2'b00};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [5:0] idx);
      @(posedge clk);
      araddr <= {24'h00_0000, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
endmodule

/* File: test/tpsic_top_tb_top.sv */
// Self-checking bench of the power, status and alert block.
// Assumes the host model drives the bus; reads are checked in order.
`timescale 1ns/1ns
`include "tpsic_regs.svh"
module tpsic_top_tb_top;
   localparam logic [5:0] iCtl = `TPSIC_IDX_CTRL, iGen = `TPSIC_IDX_GENERAL,
      iTch = `TPSIC_IDX_TOUCH, iLed = `TPSIC_IDX_LIGHT,
      iSby = `TPSIC_IDX_LOW_POWER_SCAN_EN_SEL, iIrq = `TPSIC_IDX_TOUCH_IRQ,
      iPat = `TPSIC_IDX_PAT_IRQ, iLnk = `TPSIC_IDX_LINK;
   logic                    clk, sys_rst, spi4Wire, wakeIn, wakeOut;
   logic                    wakeOe, alert_n, awvalid, awready, wvalid;
   logic                    wready, bvalid, bready, arvalid, arready;
   logic                    rvalid, rready;
   logic [31:0]             awaddr, wdata, araddr, rdata;
   logic [7:0]              k, m;
   logic [7:0]              expQ[$];
   tpsic_pkg::tpsic_evt_t   evt;
   tpsic_pkg::tpsic_sense_t sense;
   int                      failures, cmp_count, cycles, seed;

   tpsic_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .evt(evt), .sense(sense),
      .spi4Wire(spi4Wire), .wakeIn(wakeIn), .wakeOut(wakeOut),
      .wakeOe(wakeOe), .alert_n(alert_n));
   tpsic_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
      .rready(rready));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      expQ.push_back(exp);
      host.rd(idx);
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // The read monitor pairs each returned word with the oldest note.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rvalid === 1'b1 && rready === 1'b1 && expQ.size() > 0)
         check("rdata", rdata, {24'h00_0000, expQ.pop_front()});
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      sys_rst = 1'b1;
      {spi4Wire, wakeIn} = 2'h0;
      evt = '0;
      failures = 0;
      cmp_count = 0;
      cycles = 0;
      seed = 90356;
      hold(6);
      sys_rst <= 1'b0;
      hold(2);
      check("alert_n", alert_n, 1'b0);
      rd(iCtl, 8'h01);
      rd(iGen, 8'h08);
      rd(iTch, 8'h00);
      rd(iLed, 8'h00);
      rd(iSby, 8'h01);
      host.wr(iCtl, 8'h00);
      check("alert_n", alert_n, 1'b1);
      @(posedge clk) evt.resetExit <= 1'b1;
      @(posedge clk) evt.resetExit <= 1'b0;
      rd(iGen, 8'h08);
      host.wr(iCtl, 8'h00);
      host.wr(iGen, 8'hFF);
      host.wr(6'h05, 8'hFF);
      rd(iGen, 8'h00);
      rd(6'h05, 8'h00);
      for (int g = 0; g < 8; g++) begin
         host.wr(iCtl, {g[1:0], g[2], 5'h00});
         check("gain", sense.gainFactor, 4'h1 << g[1:0]);
         rd(iCtl, {g[1:0], g[2], 5'h00});
      end
      host.wr(iCtl, 8'h00);
      k = 8'h01 << ($random(seed) & 7);
      @(posedge clk) evt.touch <= k;
      hold(3);
      check("alert_n", alert_n, 1'b0);
      rd(iTch, k);
      rd(iGen, 8'h01);
      host.wr(iCtl, 8'h00);
      check("alert_n", alert_n, 1'b1);
      rd(iTch, k);
      @(posedge clk) evt.touch <= 8'h00;
      host.wr(iCtl, 8'h00);
      rd(iTch, 8'h00);
      host.wr(iIrq, ~k);
      @(posedge clk) evt.touch <= k;
      hold(3);
      check("alert_n", alert_n, 1'b1);
      @(posedge clk) evt.touch <= 8'h00;
      host.wr(iIrq, 8'hFF);
      host.wr(iCtl, 8'h00);
      m = 8'($random(seed)) | 8'h80;
      host.wr(iLnk, 8'h0F);
      check("linkMask", sense.linkMask, 8'h0F);
      @(posedge clk) evt.lightDone <= m;
      @(posedge clk) evt.lightDone <= 8'h00;
      rd(iLed, m & 8'hF0);
      rd(iGen, 8'h10);
      host.wr(iCtl, 8'h00);
      rd(iLed, 8'h00);
      host.wr(iPat, 8'h00);
      @(posedge clk) evt.patternHit <= 1'b1;
      hold(3);
      check("alert_n", alert_n, 1'b1);
      rd(iGen, 8'h02);
      @(posedge clk) evt.patternHit <= 1'b0;
      rd(iGen, 8'h00);
      host.wr(iPat, 8'h01);
      @(posedge clk) evt.patternHit <= 1'b1;
      hold(3);
      check("alert_n", alert_n, 1'b0);
      @(posedge clk) evt.patternHit <= 1'b0;
      host.wr(iCtl, 8'h00);
      @(posedge clk) evt.multiBlock <= 1'b1;
      hold(3);
      check("alert_n", alert_n, 1'b1);
      rd(iGen, 8'h04);
      @(posedge clk) evt.multiBlock <= 1'b0;
      @(posedge clk) evt.touch <= k;
      hold(3);
      host.wr(iCtl, 8'h10);
      check("alert_n", alert_n, 1'b1);
      rd(iTch, 8'h00);
      check("scan", {sense.scanEn, sense.pwmEn}, 9'h000);
      @(posedge clk) evt.touch <= 8'h02;
      @(posedge clk) wakeIn <= 1'b1;
      @(posedge clk) wakeIn <= 1'b0;
      rd(iCtl, 8'h01);
      host.wr(iCtl, 8'h00);
      host.wr(iSby, 8'h05);
      host.wr(iCtl, 8'h20);
      check("scanEn", sense.scanEn, 8'h05);
      check("linkMask", sense.linkMask, 8'h0F);
      hold(1);
      check("touchState", sense.touchState, 8'h00);
      @(posedge clk) evt.touch <= 8'h03;
      hold(3);
      check("wake", {wakeOut, wakeOe}, 2'h3);
      hold(20);
      rd(iTch, 8'h03);
      @(posedge clk) spi4Wire <= 1'b1;
      hold(2);
      check("wakeOe", wakeOe, 1'b0);
      host.wr(iCtl, 8'h20);
      check("wakeOut", wakeOut, 1'b0);
      hold(4);
      final_report();
   end
endmodule

bind tpsic_top tpsic_assertions chk (.clk(clk), .sys_rst(sys_rst),
   .evt(evt), .sense(sense), .spi4Wire(spi4Wire), .wakeIn(wakeIn),
   .wakeOut(wakeOut), .wakeOe(wakeOe), .alert_n(alert_n));
